// ===== rtl/tpmau_ctrl.v
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tpmau_map.vh"

module tpmau_ctrl #(
  parameter CNT_W = 25,
  parameter [CNT_W-1:0] JAB_CYC = `TPMAU_JAB_MS * `TPMAU_CLK_KHZ,
  parameter [CNT_W-1:0] UNJAB_CYC = `TPMAU_UNJAB_MS * `TPMAU_CLK_KHZ,
  parameter [CNT_W-1:0] LINK_TX_CYC = `TPMAU_LINK_TX_MS * `TPMAU_CLK_KHZ,
  parameter [CNT_W-1:0] LINK_LOSS_CYC = `TPMAU_LINK_LOSS_MS * `TPMAU_CLK_KHZ
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // attachment unit side
  input wire auiDoActive,
  input wire auiDoData,
  output reg auiDiData,
  output reg auiDiDrive,
  output reg auiCiData,
  output reg auiCiDrive,
  // twisted pair receive side
  input wire tpRxCarrier,
  input wire tpRxData,
  input wire tpRxPosExcursion,
  input wire tpRxNegExcursion,
  input wire endDelimiterValid,
  input wire endDelimiterNeg,
  // twisted pair transmit side
  output reg tpTxData,
  output reg tpTxEnable,
  output reg tp_predistort_out,
  // pins
  input wire heartbeat_enable_n,
  input wire testMode,
  input wire powerdown_reset_n,
  input wire link_ok_status_in,
  output reg link_ok_status_out,
  output reg link_ok_status_oe,
  input wire polarity_ok_status_in,
  output reg polarity_ok_status_out,
  output reg polarity_ok_status_oe,
  output reg transmit_active_status,
  output reg receive_active_status
);

  // ==========================================================
  // derived cycle counts
  localparam BIT_CYC = (`TPMAU_BIT_NS * 1000) / `TPMAU_CLK_PS;
  localparam LP_MIN = (`TPMAU_LP_MIN_NS * 1000 + `TPMAU_CLK_PS - 1) / `TPMAU_CLK_PS;
  localparam LP_MAX = (`TPMAU_LP_MAX_NS * 1000) / `TPMAU_CLK_PS;
  localparam PD_MIN = (`TPMAU_PD_MIN_NS * 1000 + `TPMAU_CLK_PS - 1) / `TPMAU_CLK_PS;
  localparam RST_HOLD = (`TPMAU_RST_HOLD_NS * 1000 + `TPMAU_CLK_PS - 1) / `TPMAU_CLK_PS;
  localparam HB_DELAY = `TPMAU_HB_DELAY_BITS * BIT_CYC;
  localparam HB_END = (`TPMAU_HB_DELAY_BITS + `TPMAU_HB_LEN_BITS) * BIT_CYC;
  localparam TAIL_CYC = `TPMAU_COLL_TAIL_BITS * BIT_CYC;
  localparam LPTX_CYC = `TPMAU_LP_TX_BITS * BIT_CYC;

  // synchroniser lanes
  localparam S_DOACT = 0;
  localparam S_DODAT = 1;
  localparam S_RXCAR = 2;
  localparam S_RXDAT = 3;
  localparam S_POS = 4;
  localparam S_NEG = 5;
  localparam S_ETDV = 6;
  localparam S_ETDN = 7;
  localparam S_HBN = 8;
  localparam S_TEST = 9;
  localparam S_PDN = 10;
  localparam S_LNK = 11;
  localparam S_POL = 12;
  localparam NSYNC = 13;

  // ==========================================================
  // input synchronisers
  reg [NSYNC-1:0] syncA;
  reg [NSYNC-1:0] syncB;
  reg etdSeen;
  always @(posedge clk) begin
    syncA <= {polarity_ok_status_in, link_ok_status_in, powerdown_reset_n, testMode, heartbeat_enable_n,
              endDelimiterNeg, endDelimiterValid, tpRxNegExcursion, tpRxPosExcursion, tpRxData,
              tpRxCarrier, auiDoData, auiDoActive};
    syncB <= syncA;
    etdSeen <= syncB[S_ETDV];
  end

  wire doAct = syncB[S_DOACT];
  wire doDat = syncB[S_DODAT];
  wire rxCar = syncB[S_RXCAR];
  wire inTest = syncB[S_TEST];
  wire hbOn = ~syncB[S_HBN];
  wire etdEvent = syncB[S_ETDV] & ~etdSeen;

  // ==========================================================
  // power-down filter and reset stretch
  reg [11:0] pdCnt;
  reg pdActive;
  reg [31:0] ctrlReg;
  always @(posedge clk) begin
    if (sys_rst) begin
      pdCnt <= 12'h000;
      pdActive <= 1'b1;
    end else if (!syncB[S_PDN]) begin
      if (pdCnt >= PD_MIN[11:0] - 12'h001) begin
        pdActive <= 1'b1;
        pdCnt <= 12'h000;
      end else if (!pdActive) begin
        pdCnt <= pdCnt + 12'h001;
      end
    end else if (pdActive) begin
      if (pdCnt >= RST_HOLD[11:0]) begin
        pdActive <= 1'b0;
        pdCnt <= 12'h000;
      end else begin
        pdCnt <= pdCnt + 12'h001;
      end
    end else begin
      pdCnt <= 12'h000;
    end
  end
  wire coreRst = sys_rst | pdActive | ctrlReg[`TPMAU_CTRL_PD_BIT];

  // ==========================================================
  // bit tick, strap capture
  reg [1:0] clkDiv;
  reg [1:0] strapCnt;
  reg strapDone;
  reg linkChkOff;
  reg polCorrOff;
  wire osc = clkDiv[1];
  always @(posedge clk) begin
    if (coreRst) begin
      clkDiv <= 2'h0;
      strapCnt <= 2'h0;
      strapDone <= 1'b0;
      linkChkOff <= 1'b0;
      polCorrOff <= 1'b0;
    end else begin
      clkDiv <= clkDiv + 2'h1;
      if (!strapDone) begin
        strapCnt <= strapCnt + 2'h1;
        if (strapCnt == `TPMAU_STRAP_WAIT) begin
          strapDone <= 1'b1;
          linkChkOff <= ~syncB[S_LNK];
          polCorrOff <= ~syncB[S_POL];
        end
      end
    end
  end

  // ==========================================================
  // link pulse classifier
  reg [3:0] posW;
  reg [3:0] negW;
  reg [3:0] blank;
  reg lastPos;
  reg lastNeg;
  wire posEnd = lastPos & ~syncB[S_POS];
  wire negEnd = lastNeg & ~syncB[S_NEG];
  wire posOk = posEnd & (posW >= LP_MIN[3:0]) & (posW <= LP_MAX[3:0]);
  wire negOk = negEnd & (negW >= LP_MIN[3:0]) & (negW <= LP_MAX[3:0]);
  wire lpEvent = ~rxCar & (blank == 4'h0) & (posOk | negOk);
  wire lpNeg = negOk & ~posOk;
  always @(posedge clk) begin
    if (coreRst) begin
      posW <= 4'h0;
      negW <= 4'h0;
      blank <= 4'h0;
      lastPos <= 1'b0;
      lastNeg <= 1'b0;
    end else begin
      lastPos <= syncB[S_POS];
      lastNeg <= syncB[S_NEG];
      posW <= syncB[S_POS] ? ((posW == 4'hf) ? posW : posW + 4'h1) : 4'h0;
      negW <= syncB[S_NEG] ? ((negW == 4'hf) ? negW : negW + 4'h1) : 4'h0;
      // the trailing opposite excursion of a pulse is not a pulse of its own
      if (lpEvent)
        blank <= LP_MAX[3:0];
      else if (blank != 4'h0)
        blank <= blank - 4'h1;
    end
  end

  // ==========================================================
  // link integrity and receive polarity
  reg linkPass;
  reg [CNT_W-1:0] lossCnt;
  reg [2:0] runCnt;
  reg runNeg;
  reg rxInvert;
  reg polArmed;
  reg polFirst;
  wire linkOk = linkPass | linkChkOff;
  wire lpMatch = lpEvent & (polCorrOff | (lpNeg == rxInvert));
  always @(posedge clk) begin
    if (coreRst) begin
      linkPass <= 1'b0;
      lossCnt <= {CNT_W{1'b0}};
      runCnt <= 3'h0;
      runNeg <= 1'b0;
      rxInvert <= 1'b0;
      polArmed <= 1'b1;
      polFirst <= 1'b0;
    end else begin
      if (!linkPass) begin
        lossCnt <= {CNT_W{1'b0}};
        if (rxCar) begin
          linkPass <= 1'b1;
          runCnt <= 3'h0;
        end else if (lpEvent) begin
          if (runCnt != 3'h0 && lpNeg == runNeg) begin
            if (runCnt == `TPMAU_LP_RUN - 1) begin
              linkPass <= 1'b1;
              runCnt <= 3'h0;
              rxInvert <= lpNeg & ~polCorrOff;
            end else begin
              runCnt <= runCnt + 3'h1;
            end
          end else begin
            runCnt <= 3'h1;
            runNeg <= lpNeg;
          end
        end
      end else if (rxCar || lpMatch) begin
        lossCnt <= {CNT_W{1'b0}};
      end else if (lossCnt >= LINK_LOSS_CYC) begin
        linkPass <= 1'b0;
        polArmed <= 1'b1;
        polFirst <= 1'b0;
        lossCnt <= {CNT_W{1'b0}};
      end else begin
        lossCnt <= lossCnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // only valid delimiters reach here; invalid packets leave polarity alone
      if (etdEvent && polArmed && !polCorrOff && linkOk) begin
        if (!polFirst) begin
          rxInvert <= syncB[S_ETDN];
          polFirst <= 1'b1;
        end else if (syncB[S_ETDN] == rxInvert) begin
          polArmed <= 1'b0;
        end else begin
          rxInvert <= syncB[S_ETDN];
        end
      end
    end
  end
  wire rxCorr = syncB[S_RXDAT] ^ (rxInvert & ~polCorrOff);

  // ==========================================================
  // jabber, collision tail, heartbeat, link pulse timer
  reg jabber;
  reg [CNT_W-1:0] jabCnt;
  reg [3:0] tailCnt;
  reg collPrev;
  reg [6:0] hbCnt;
  reg hbRun;
  reg doPrev;
  reg [CNT_W-1:0] lpTxCnt;
  reg [2:0] lpTxLeft;
  wire collision = ~inTest & linkOk & doAct & rxCar;
  wire hbBurst = hbRun & (hbCnt >= HB_DELAY[6:0]);
  // a jabbered transmitter stays silent, link pulses included
  wire txBusy = (tpTxEnable & (lpTxLeft == 3'h0)) | jabber;
  always @(posedge clk) begin
    if (coreRst) begin
      jabber <= 1'b0;
      jabCnt <= {CNT_W{1'b0}};
      tailCnt <= 4'h0;
      collPrev <= 1'b0;
      hbCnt <= 7'h00;
      hbRun <= 1'b0;
      doPrev <= 1'b0;
      lpTxCnt <= {CNT_W{1'b0}};
      lpTxLeft <= 3'h0;
    end else begin
      doPrev <= doAct;
      collPrev <= collision;
      if (inTest) begin
        jabber <= 1'b0;
        jabCnt <= {CNT_W{1'b0}};
      end else if (!jabber) begin
        jabCnt <= doAct ? jabCnt + {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
        if (doAct && jabCnt >= JAB_CYC) begin
          jabber <= 1'b1;
          jabCnt <= {CNT_W{1'b0}};
        end
      end else if (doAct) begin
        jabCnt <= {CNT_W{1'b0}};
      end else if (jabCnt >= UNJAB_CYC) begin
        jabber <= 1'b0;
      end else begin
        jabCnt <= jabCnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (collPrev && !collision)
        tailCnt <= TAIL_CYC[3:0] - 4'h1;
      else if (tailCnt != 4'h0)
        tailCnt <= tailCnt - 4'h1;
      if (doAct || inTest || !hbOn) begin
        hbRun <= 1'b0;
        hbCnt <= 7'h00;
      end else if (doPrev) begin
        hbRun <= 1'b1;
        hbCnt <= 7'h00;
      end else if (hbRun) begin
        if (hbCnt == HB_END[6:0] - 7'h01)
          hbRun <= 1'b0;
        hbCnt <= hbCnt + 7'h01;
      end
      if (txBusy) begin
        lpTxCnt <= {CNT_W{1'b0}};
        lpTxLeft <= 3'h0;
      end else if (lpTxLeft != 3'h0) begin
        lpTxLeft <= lpTxLeft - 3'h1;
      end else if (lpTxCnt >= LINK_TX_CYC) begin
        lpTxCnt <= {CNT_W{1'b0}};
        lpTxLeft <= LPTX_CYC[2:0];
      end else begin
        lpTxCnt <= lpTxCnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // data paths and status
  reg next_txEn;
  reg next_txData;
  reg next_diDrive;
  reg next_diData;
  reg next_ciDrive;
  reg next_ciData;
  reg next_xmt;
  reg next_rcv;
  reg [1:0] steady;
  always @* begin
    next_txEn = 1'b0;
    next_txData = 1'b0;
    next_diDrive = 1'b0;
    next_diData = 1'b1;
    next_xmt = 1'b0;
    next_rcv = 1'b0;
    if (inTest && !syncB[S_HBN]) begin
      next_txEn = doAct;
      next_txData = doDat;
      next_diDrive = rxCar;
      next_diData = rxCar ? rxCorr : 1'b1;
      next_xmt = doAct;
      next_rcv = rxCar;
    end else if (inTest) begin
      next_txEn = rxCar;
      next_txData = rxCorr;
      next_diDrive = doAct;
      next_diData = doAct ? doDat : 1'b1;
      next_xmt = rxCar;
      next_rcv = doAct;
    end else begin
      next_txEn = doAct & linkOk & ~jabber;
      next_txData = doDat;
      next_diDrive = rxCar & linkOk;
      next_diData = next_diDrive ? rxCorr : 1'b1;
      next_xmt = next_txEn | (collision & ~jabber);
      next_rcv = next_diDrive | collision;
    end
    if (!next_txEn && lpTxLeft != 3'h0) begin
      next_txEn = 1'b1;
      next_txData = 1'b1;
    end
    if (inTest) begin
      next_ciDrive = 1'b0;
      next_ciData = 1'b1;
    end else if (collision || jabber) begin
      next_ciDrive = 1'b1;
      next_ciData = osc;
    end else if (collPrev || tailCnt != 4'h0) begin
      next_ciDrive = 1'b1;
      next_ciData = 1'b1;
    end else if (hbBurst) begin
      next_ciDrive = 1'b1;
      next_ciData = osc;
    end else begin
      next_ciDrive = 1'b0;
      next_ciData = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (coreRst) begin
      tpTxEnable <= 1'b0;
      tpTxData <= 1'b0;
      tp_predistort_out <= 1'b0;
      steady <= 2'h0;
      auiDiDrive <= 1'b0;
      auiDiData <= 1'b1;
      auiCiDrive <= 1'b0;
      auiCiData <= 1'b1;
      transmit_active_status <= 1'b0;
      receive_active_status <= 1'b0;
      link_ok_status_out <= 1'b0;
      link_ok_status_oe <= 1'b0;
      polarity_ok_status_out <= 1'b0;
      polarity_ok_status_oe <= 1'b0;
    end else begin
      tpTxEnable <= next_txEn;
      tpTxData <= next_txData;
      // weakened drive once a level has outlasted half a bit
      steady <= (next_txData != tpTxData) ? 2'h0 : ((steady == 2'h3) ? steady : steady + 2'h1);
      tp_predistort_out <= next_txEn & (next_txData == tpTxData) & (steady != 2'h0);
      auiDiDrive <= next_diDrive;
      auiDiData <= next_diData;
      auiCiDrive <= next_ciDrive;
      auiCiData <= next_ciData;
      transmit_active_status <= next_xmt;
      receive_active_status <= next_rcv;
      link_ok_status_out <= 1'b0;
      link_ok_status_oe <= strapDone & linkPass & ~linkChkOff;
      polarity_ok_status_out <= 1'b0;
      polarity_ok_status_oe <= strapDone & ~polCorrOff & ~rxInvert;
    end
  end

  // ==========================================================
  // register bus slave
  reg awHeld;
  reg wHeld;
  reg [7:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire [31:0] statusWord = {22'h00_0000, polCorrOff, linkChkOff, inTest, receive_active_status,
                            transmit_active_status, collision, jabber, ~polArmed, rxInvert, linkOk};
  integer i;
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPMAU_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TPMAU_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      ctrlReg <= `TPMAU_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr == `TPMAU_ADDR_CTRL) begin
          s_axi_bresp <= `TPMAU_RESP_OKAY;
          for (i = 0; i < 4; i = i + 1)
            if (wStrb[i])
              ctrlReg[i*8 +: 8] <= wData[i*8 +: 8];
        end else if (awAddr == `TPMAU_ADDR_STATUS) begin
          s_axi_bresp <= `TPMAU_RESP_OKAY;
        end else begin
          s_axi_bresp <= `TPMAU_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `TPMAU_ADDR_CTRL) begin
          s_axi_rdata <= {31'h0000_0000, ctrlReg[`TPMAU_CTRL_PD_BIT]};
          s_axi_rresp <= `TPMAU_RESP_OKAY;
        end else if (s_axi_araddr == `TPMAU_ADDR_STATUS) begin
          s_axi_rdata <= statusWord;
          s_axi_rresp <= `TPMAU_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TPMAU_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== rtl/tpmau_map.vh
`ifndef TPMAU_MAP_VH
`define TPMAU_MAP_VH

// ==========================================================
// clock and time base
`define TPMAU_CLK_KHZ 40000
`define TPMAU_CLK_PS 25000
`define TPMAU_BIT_NS 100

// ==========================================================
// link pulse, reset and sequence timing
`define TPMAU_LP_MIN_NS 60
`define TPMAU_LP_MAX_NS 200
`define TPMAU_LP_RUN 5
`define TPMAU_LP_TX_BITS 1
`define TPMAU_LINK_TX_MS 16
`define TPMAU_LINK_LOSS_MS 100
`define TPMAU_JAB_MS 50
`define TPMAU_UNJAB_MS 500
`define TPMAU_PD_MIN_NS 2000
`define TPMAU_RST_HOLD_NS 10000
`define TPMAU_HB_DELAY_BITS 8
`define TPMAU_HB_LEN_BITS 8
`define TPMAU_COLL_TAIL_BITS 2
`define TPMAU_STRAP_WAIT 3

// ==========================================================
// register map
`define TPMAU_ADDR_CTRL 8'h00
`define TPMAU_ADDR_STATUS 8'h04
`define TPMAU_CTRL_PD_BIT 0
`define TPMAU_ST_LINK_OK 0
`define TPMAU_ST_RX_INVERT 1
`define TPMAU_ST_POL_LOCKED 2
`define TPMAU_ST_JABBER 3
`define TPMAU_ST_COLLISION 4
`define TPMAU_ST_XMT 5
`define TPMAU_ST_RCV 6
`define TPMAU_ST_TEST 7
`define TPMAU_ST_LINK_CHK_OFF 8
`define TPMAU_ST_POL_CORR_OFF 9
`define TPMAU_RESP_OKAY 2'h0
`define TPMAU_RESP_SLVERR 2'h2
`define TPMAU_CTRL_RESET 32'h0000_0000

`endif

// ===== tb/tpmau_station.sv
`timescale 1ns/1ps
module tpmau_station (
  // clock and frame request
  input wire clk,
  input wire startFrame,
  input wire [15:0] frameBits,
  // attachment unit side
  input wire auiCiDrive,
  output reg auiDoActive,
  output reg auiDoData,
  output reg [15:0] ciCycles
);
  reg [17:0] left = 18'h0_0000;
  initial begin
    auiDoActive = 1'h0;
    auiDoData = 1'h0;
    ciCycles = 16'h0000;
  end
  // ==========================================================
  // frame of four clocks per bit, counting CI activity from the frame's start
  always @(posedge clk) begin
    if (auiCiDrive)
      ciCycles <= ciCycles + 16'h0001;
    if (startFrame && left == 0) begin
      left <= {frameBits, 2'h0};
      ciCycles <= 16'h0000;
    end else if (left != 0) begin
      left <= left - 18'h0_0001;
    end
    auiDoActive <= left != 0;
    // idle line toggles so no stale level is mistaken for data
    auiDoData <= (left != 0) ? left[2] : !auiDoData;
  end
endmodule

// ===== tb/tpmau_ctrl_chk.sv
`timescale 1ns/1ps
module tpmau_ctrl_chk #(
  parameter JAB_CYC = 200
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // bus response
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // pins
  input wire testMode,
  input wire auiDoActive,
  input wire powerdown_reset_n,
  input wire link_ok_status_out,
  input wire link_ok_status_oe,
  input wire polarity_ok_status_out,
  input wire auiCiData,
  input wire auiCiDrive,
  input wire auiDiDrive,
  input wire tpTxEnable,
  input wire tpTxData,
  input wire transmit_active_status,
  input wire receive_active_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [15:0] doCnt;
  reg [7:0] pdLow;
  always @(posedge clk) begin
    doCnt <= (sys_rst || !auiDoActive) ? 16'h0000 : doCnt + 16'h0001;
    pdLow <= (sys_rst || powerdown_reset_n) ? 8'h00 : pdLow + {7'h00, pdLow != 8'hff};
  end
  sequence s_osc; (auiCiDrive && !auiCiData) [*2]; endsequence
  sequence s_lpulse; (tpTxEnable && tpTxData) [*4] ##1 (!tpTxEnable || $past(auiDoActive, 3)); endsequence
  property p_od; !link_ok_status_out && !polarity_ok_status_out; endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  property p_osc; s_osc |=> auiCiData || !auiCiDrive; endproperty
  a_osc: assert property (p_osc) else $error("CI not a 10 MHz square");
  property p_lp; $rose(tpTxEnable) && !auiDoActive && !testMode && !receive_active_status |-> s_lpulse; endproperty
  a_lp: assert property (p_lp) else $error("idle link pulse malformed");
  property p_xmt; transmit_active_status && !testMode |-> tpTxEnable; endproperty
  a_xmt: assert property (p_xmt) else $error("transmit status without transmit");
  property p_jab; doCnt > JAB_CYC + 8 && !testMode |-> !transmit_active_status && !tpTxEnable && auiCiDrive; endproperty
  a_jab: assert property (p_jab) else $error("jabber not cut off");
  property p_pd; pdLow > 8'h5a |-> !tpTxEnable && !auiCiDrive && !auiDiDrive && !link_ok_status_oe; endproperty
  a_pd: assert property (p_pd) else $error("outputs active in power-down");
  property p_di; receive_active_status && !testMode |-> auiDiDrive; endproperty
  a_di: assert property (p_di) else $error("receive status without DI");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind tpmau_ctrl tpmau_ctrl_chk #(.JAB_CYC(JAB_CYC)) u_chk (.clk, .sys_rst, .s_axi_bvalid, .s_axi_bready, .testMode,
  .auiDoActive, .powerdown_reset_n, .link_ok_status_out, .link_ok_status_oe, .polarity_ok_status_out, .auiCiData,
  .auiCiDrive, .auiDiDrive, .tpTxEnable, .tpTxData, .transmit_active_status, .receive_active_status);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk = 0;
  reg sys_rst = 1;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg tpRxCarrier = 0, tpRxData = 0, tpRxPosExcursion = 0, tpRxNegExcursion = 0, endDelimiterValid = 0;
  reg endDelimiterNeg = 0, heartbeat_enable_n = 1, testMode = 0, powerdown_reset_n = 1, linkGnd = 0, polGnd = 0;
  reg go = 0;
  reg [15:0] bits = 0;
  wire auiDoActive, auiDoData, auiDiData, auiDiDrive, auiCiData, auiCiDrive, tpTxData, tpTxEnable, tp_predistort_out;
  wire link_ok_status_out, link_ok_status_oe, polarity_ok_status_out, polarity_ok_status_oe;
  wire transmit_active_status, receive_active_status;
  wire [15:0] ciCycles;
  // open-drain pins: pulled up unless strapped to ground
  wire link_ok_status_in = link_ok_status_oe ? link_ok_status_out : !linkGnd;
  wire polarity_ok_status_in = polarity_ok_status_oe ? polarity_ok_status_out : !polGnd;
  integer n_errors = 0, compares = 0, cyc = 0, hb;
  reg [31:0] d;

  tpmau_ctrl #(.JAB_CYC(200), .UNJAB_CYC(400), .LINK_TX_CYC(300), .LINK_LOSS_CYC(2000)) DUT (.clk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auiDoActive, .auiDoData, .auiDiData, .auiDiDrive, .auiCiData,
    .auiCiDrive, .tpRxCarrier, .tpRxData, .tpRxPosExcursion, .tpRxNegExcursion, .endDelimiterValid,
    .endDelimiterNeg, .tpTxData, .tpTxEnable, .tp_predistort_out, .heartbeat_enable_n, .testMode,
    .powerdown_reset_n, .link_ok_status_in, .link_ok_status_out, .link_ok_status_oe, .polarity_ok_status_in,
    .polarity_ok_status_out, .polarity_ok_status_oe, .transmit_active_status, .receive_active_status);
  tpmau_station u_station (.clk, .startFrame(go), .frameBits(bits), .auiCiDrive, .auiDoActive, .auiDoData,
    .ciCycles);

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 15000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  // ==========================================================
  // helpers
  task w(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task axw(input [7:0] a, input [31:0] v, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task axr(input [7:0] a, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  task lp(input integer n, input integer wd);
    repeat (n) begin
      tpRxPosExcursion <= 1;
      w(wd);
      tpRxPosExcursion <= 0;
      w(40);
    end
  endtask
  task pkt(input v, input ng);
    tpRxCarrier <= 1;
    tpRxData <= 1;
    w(20);
    endDelimiterNeg <= ng;
    endDelimiterValid <= v;
    w(4);
    endDelimiterValid <= 0;
    tpRxCarrier <= 0;
    w(20);
  endtask
  task frm(input [15:0] b);
    bits <= b;
    go <= 1;
    @(posedge clk);
    go <= 0;
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    axr(8'h00, 0);
    chk(d, 0);
    axr(8'h08, 2);
    chk(d, 0);
    axw(8'h08, 1, 2);
    axw(8'h00, 1, 0);
    axr(8'h00, 0);
    chk(d, 1);
    axw(8'h00, 0, 0);
    $display("t_regs end");
  endtask
  task t_link;
    chk(link_ok_status_oe, 0);
    lp(5, 2);
    lp(4, 4);
    chk(link_ok_status_oe, 0);
    lp(1, 4);
    chk(link_ok_status_oe, 1);
    chk(polarity_ok_status_oe, 1);
    axr(8'h04, 0);
    chk(d[0], 1);
    $display("t_link end");
  endtask
  task t_rx;
    tpRxCarrier <= 1;
    tpRxData <= 1;
    w(8);
    chk({receive_active_status, auiDiDrive, auiDiData}, 7);
    tpRxData <= 0;
    w(5);
    chk(auiDiData, 0);
    tpRxCarrier <= 0;
    w(6);
    chk(receive_active_status, 0);
    pkt(1, 1);
    chk(polarity_ok_status_oe, 0);
    pkt(0, 0);
    chk(polarity_ok_status_oe, 0);
    pkt(1, 0);
    chk(polarity_ok_status_oe, 1);
    pkt(1, 0);
    pkt(1, 1);
    chk(polarity_ok_status_oe, 1);
    axr(8'h04, 0);
    chk(d[2], 1);
    $display("t_rx end");
  endtask
  task t_tx;
    for (hb = 0; hb < 2; hb = hb + 1) begin
      heartbeat_enable_n <= hb[0];
      frm(20);
      w(40);
      chk({transmit_active_status, tpTxEnable}, 3);
      w(150);
      chk(ciCycles, hb ? 0 : 32);
    end
    $display("t_tx end");
  endtask
  task t_coll;
    frm(40);
    w(20);
    tpRxCarrier <= 1;
    w(40);
    chk({auiCiDrive, transmit_active_status, receive_active_status}, 7);
    tpRxCarrier <= 0;
    w(6);
    chk({auiCiDrive, auiCiData}, 3);
    w(8);
    chk(auiCiDrive, 0);
    w(120);
    $display("t_coll end");
  endtask
  task t_jab;
    lp(2, 4);
    frm(150);
    w(300);
    chk({transmit_active_status, tpTxEnable, auiCiDrive}, 1);
    w(600);
    chk(auiCiDrive, 1);
    w(200);
    chk(auiCiDrive, 0);
    $display("t_jab end");
  endtask
  task t_loop;
    lp(2, 4);
    testMode <= 1;
    for (hb = 0; hb < 2; hb = hb + 1) begin
      heartbeat_enable_n <= hb[0];
      w(10);
      frm(30);
      w(40);
      chk({tpTxEnable, auiDiDrive}, hb ? 1 : 2);
      w(100);
      tpRxCarrier <= 1;
      w(10);
      chk({tpTxEnable, auiDiDrive}, hb ? 2 : 1);
      tpRxCarrier <= 0;
      w(10);
    end
    testMode <= 0;
    $display("t_loop end");
  endtask
  task t_pd;
    w(2100);
    chk(link_ok_status_oe, 0);
    tpRxCarrier <= 1;
    w(8);
    chk(link_ok_status_oe, 1);
    tpRxCarrier <= 0;
    powerdown_reset_n <= 0;
    linkGnd <= 1;
    polGnd <= 1;
    w(90);
    chk({tpTxEnable, tp_predistort_out, auiCiDrive, auiCiData, transmit_active_status, link_ok_status_oe}, 4);
    powerdown_reset_n <= 1;
    w(380);
    tpRxCarrier <= 1;
    w(8);
    chk(receive_active_status, 0);
    tpRxCarrier <= 0;
    w(60);
    pkt(1, 1);
    tpRxCarrier <= 1;
    w(8);
    chk({receive_active_status, auiDiData}, 3);
    tpRxCarrier <= 0;
    axr(8'h04, 0);
    chk(d[9:8], 3);
    $display("t_pd end");
  endtask
  task tally_and_finish;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    w(6);
    sys_rst <= 0;
    w(420);
    t_regs;
    w(450);
    t_link;
    t_rx;
    t_tx;
    t_coll;
    t_jab;
    t_loop;
    t_pd;
    tally_and_finish;
  end
endmodule
